// ===== bench/rsc_checker.sv
// port assertions for the reset sequence controller
// assumes binding into rsc_top, one aclk domain
module rsc_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire rsc_pkg::rsc_axi_req_type axi_req,
	input wire rsc_pkg::rsc_axi_rsp_type axi_rsp,
	// pins and status
	input wire logic power_on_release_n,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic normal_run_state,
	input wire logic self_test_controller_run,
	input wire logic smps_test_run
);
	import rsc_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence oe_drop;
		$fell(reset_pin_oe);
	endsequence
	sequence pin_free;
		reset_pin_in [*6];
	endsequence
	AST_OUT_LOW: assert property (reset_pin_out == 1'h0)
		else $error("pin driven high");
	AST_RUN_RELEASED: assert property (normal_run_state |-> !reset_pin_oe)
		else $error("run while pin pulled");
	AST_RUN_AFTER_PIN: assert property ($rose(normal_run_state) |-> $past(reset_pin_in, 2))
		else $error("run before pin high");
	AST_RUN_NO_TEST: assert property (normal_run_state |-> !(self_test_controller_run || smps_test_run))
		else $error("test in run");
	AST_POR_HOLD: assert property (!power_on_release_n [*5] |-> !normal_run_state)
		else $error("run while por low");
	AST_TEST_DRIVES: assert property ((self_test_controller_run || smps_test_run) |-> reset_pin_oe)
		else $error("test without pin low");
	AST_RELEASE_RUN: assert property (oe_drop ##0 pin_free |-> normal_run_state)
		else $error("no run after release");
	AST_BVALID_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
		else $error("bvalid dropped");
endmodule
bind rsc_top rsc_checker u_chk (.aclk, .aresetn, .axi_req, .axi_rsp, .power_on_release_n, .reset_pin_in,
	.reset_pin_out, .reset_pin_oe, .normal_run_state, .self_test_controller_run, .smps_test_run);

// ===== bench/rsc_ext_partner.sv
// power controller and external reset generator model
// assumes a pulled-up reset pin; bench sets por_on and hold_on
module rsc_ext_partner (
	// clock
	input wire logic aclk,
	// requests from the bench
	input wire logic por_on,
	input wire logic hold_on,
	// pins
	input wire logic reset_pin_oe,
	output logic power_on_release_n,
	output logic reset_pin_in
);
	logic [3:0] ramp_reg;
	// release only once supplies have settled
	always_ff @(posedge aclk) begin
		if (!por_on)
			ramp_reg <= 4'h0;
		else if (ramp_reg != 4'hf)
			ramp_reg <= ramp_reg + 4'h1;
	end
	assign power_on_release_n = (ramp_reg == 4'hf);
	// pull-up wins unless a party pulls low
	assign reset_pin_in = !(reset_pin_oe || hold_on);
endmodule

// ===== bench/tb.sv
// testbench for the reset sequence controller
// assumes shortened durations via parameters
`include "rsc_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rsc_pkg::*;
	localparam int DRB = 2000;
	localparam int DR = 200;
	localparam int FRS = 10;
	logic aclk, aresetn, ext_reg, destr, ext_c, por_on, hold_on;
	logic por_n, pin_in, pin_oe, run, bist, smps, low_voltage_detector, high_voltage_detector;
	rsc_axi_req_type q;
	rsc_axi_rsp_type s;
	int fail_count, samples_checked, oe_n, low_n, bist_n, smps_n;
	logic [31:0] rd;
	logic [1:0] rr;
	rsc_top #(.DRB_CYC(DRB), .ERLB_CYC(DRB), .DR_CYC(DR), .FRL_CYC(DR), .FRS_CYC(FRS), .SMPS_CYC(16)) DUT (
		.aclk, .aresetn, .axi_req(q), .axi_rsp(s), .power_on_release_n(por_n), .ext_regulation(ext_reg),
		.destructive_cause(destr), .external_cause(ext_c), .reset_pin_in(pin_in), .reset_pin_out(),
		.reset_pin_oe(pin_oe), .normal_run_state(run), .self_test_controller_run(bist),
		.smps_test_run(smps), .low_voltage_detector_en(low_voltage_detector), .high_voltage_detector_en(high_voltage_detector));
	rsc_ext_partner u_ext (.aclk, .por_on, .hold_on, .reset_pin_oe(pin_oe),
		.power_on_release_n(por_n), .reset_pin_in(pin_in));
	initial begin
		aclk = 1'h0;
		forever #20 aclk = !aclk;
	end
	task summarize;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task rng(input int g, input int lo, input int hi);
		samples_checked++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("Error %0t: %0d cycles not in %0d..%0d", $time, g, lo, hi);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		q.awaddr <= a;
		q.wdata <= d;
		q.wstrb <= 4'hf;
		q.awvalid <= 1'h1;
		q.wvalid <= 1'h1;
		q.bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s.awready) q.awvalid <= 1'h0;
			if (s.wready) q.wvalid <= 1'h0;
		end while (s.bvalid !== 1'h1);
		q.bready <= 1'h0;
		rr = s.bresp;
	endtask
	task rd_t(input logic [7:0] a);
		@(posedge aclk);
		q.araddr <= a;
		q.arvalid <= 1'h1;
		q.rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s.arready) q.arvalid <= 1'h0;
		end while (s.rvalid !== 1'h1);
		q.rready <= 1'h0;
		rd = s.rdata;
		rr = s.rresp;
	endtask
	task meas;
		oe_n = 0;
		low_n = 0;
		bist_n = 0;
		smps_n = 0;
		while (run === 1'h1) @(posedge aclk);
		while (run !== 1'h1) begin
			@(posedge aclk);
			low_n++;
			oe_n += pin_oe;
			bist_n += bist;
			smps_n += smps;
		end
	endtask
	task por_cycle(input logic d, input logic e);
		@(posedge aclk);
		por_on <= 1'h0;
		destr <= d;
		ext_c <= e;
		repeat (5) @(posedge aclk);
		por_on <= 1'h1;
		meas;
	endtask
	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		$display("Error %0t: timeout", $time);
		summarize;
	end
	initial begin
		aresetn = 1'h0;
		q = '0;
		ext_reg = 1'h1;
		destr = 1'h1;
		ext_c = 1'h0;
		por_on = 1'h0;
		hold_on = 1'h0;
		fail_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (4) @(posedge aclk);
		por_on <= 1'h1;
		meas;
		rng(low_n, DRB, DRB * 50 / 15);
		chk(bist_n > 0, 1);
		chk(smps_n > 0, 1);
		chk({low_voltage_detector, high_voltage_detector}, 0);
		rd_t(`RSC_OFS_CTRL);
		chk(rd, 32'h0000_0021);
		rd_t(`RSC_OFS_CAUSE);
		chk(rd, 32'h0000_0002);
		rd_t(8'h10);
		chk(rr, `RSC_RESP_SLVERR);
		wr(`RSC_OFS_STATUS, 32'h0000_0000);
		chk(rr, `RSC_RESP_SLVERR);
		wr(`RSC_OFS_CTRL, 32'h0000_001e);
		chk(rr, `RSC_RESP_OKAY);
		@(posedge aclk);
		chk({low_voltage_detector, high_voltage_detector}, 2'h3);
		$display("test destructive done");
		wr(`RSC_OFS_CAUSE, 32'h0000_0001);
		meas;
		rng(low_n, DR, DR * 5);
		chk(oe_n > 0, 1);
		chk(bist_n, 0);
		wr(`RSC_OFS_CTRL, 32'h0000_0000);
		wr(`RSC_OFS_CAUSE, 32'h0000_0001);
		meas;
		rng(low_n, FRS, FRS * 500);
		chk(oe_n, 0);
		chk(bist_n, 0);
		$display("test functional done");
		ext_reg <= 1'h0;
		por_cycle(1'h0, 1'h1);
		rng(low_n, DRB, DRB * 50 / 15);
		chk(bist_n > 0, 1);
		chk({low_voltage_detector, high_voltage_detector}, 2'h3);
		por_cycle(1'h0, 1'h0);
		rng(low_n, DR, DR * 5);
		chk(smps_n > 0, 1);
		hold_on <= 1'h1;
		fork
			begin
				repeat (600) @(posedge aclk);
				hold_on <= 1'h0;
			end
		join_none
		por_cycle(1'h0, 1'h0);
		rng(low_n, 590, 610);
		$display("test external done");
		summarize;
	end
endmodule

// ===== logic/rsc_cfg.svh
// reset sequence controller constants: offsets, fields, resets, timing
// assumes a 25 MHz aclk; included by the package and the top module
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_CLK_HZ 25000000
// sequence durations as printed, in microseconds
`define RSC_DRB_MIN_US 15000
`define RSC_DRB_MAX_US 50000
`define RSC_DR_MIN_US 400
`define RSC_DR_MAX_US 2000
`define RSC_ERLB_MIN_US 15000
`define RSC_ERLB_MAX_US 50000
`define RSC_FRL_MIN_US 400
`define RSC_FRL_MAX_US 2000
`define RSC_FRS_MIN_US 1
`define RSC_FRS_MAX_US 500
// base rate and regulator self test length in cycles
`define RSC_HZ_PER_MHZ 1000000
`define RSC_SMPS_CYC 64
// register byte offsets
`define RSC_OFS_CTRL 8'h00
`define RSC_OFS_CAUSE 8'h04
`define RSC_OFS_STATUS 8'h08
`define RSC_OFS_PHASE 8'h0c
// control fields
`define RSC_CTRL_BIST 0
`define RSC_CTRL_FUNC_LONG 1
`define RSC_CTRL_PIN_EN 2
`define RSC_CTRL_LVD 3
`define RSC_CTRL_HVD 4
`define RSC_CTRL_EXT_REG 5
`define RSC_CTRL_RESET 32'h0000_0001
// cause register: writing a one requests a functional reset
`define RSC_CAUSE_FUNC 0
// axi responses
`define RSC_RESP_OKAY 2'b00
`define RSC_RESP_SLVERR 2'b10
`endif

// ===== logic/rsc_pkg.sv
// types shared by the reset sequence controller
// assumes rsc_cfg.svh for constants
`include "rsc_cfg.svh"
package rsc_pkg;
	typedef enum logic [2:0] {
		seq_destr_bist,
		seq_destr_plain,
		seq_ext_long_bist,
		seq_func_long,
		seq_func_short
	} rsc_seq_type;
	typedef enum logic [2:0] {
		st_por_hold,
		st_reset_run,
		st_final_phase,
		st_pin_wait,
		st_normal_run
	} rsc_state_type;
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} rsc_axi_req_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} rsc_axi_rsp_type;
endpackage

// ===== logic/rsc_top.sv
// reset sequence controller: sequencer, reset pin control, axi4-lite registers
// assumes a 25 MHz aclk and asynchronous pins power_on_release_n, reset pin in
// Behaviour
// - destructive with self test: 15 to 50 ms
// - destructive without self test: 400 to 2000 us
// - external long with self test: 15 to 50 ms
// - functional long: 400 to 2000 us
// - functional short: 1 to 500 us
// - never self test on functional short
// - sequence ends entering normal run state
// - regulator self test in every destructive final phase
// - power-on release deassertion starts the sequence
// - reset pin open drain, low active
// - drop low drive at the release instant
// - external low hold extends the sequence
// - functional drive pin only when enabled
// - voltage detectors off by default externally regulated
`include "rsc_cfg.svh"
module rsc_top #(
	parameter int unsigned CLK_HZ = `RSC_CLK_HZ,
	parameter int unsigned DRB_CYC = `RSC_DRB_MIN_US * (CLK_HZ / `RSC_HZ_PER_MHZ),
	parameter int unsigned ERLB_CYC = `RSC_ERLB_MIN_US * (CLK_HZ / `RSC_HZ_PER_MHZ),
	parameter int unsigned DR_CYC = `RSC_DR_MIN_US * (CLK_HZ / `RSC_HZ_PER_MHZ),
	parameter int unsigned FRL_CYC = `RSC_FRL_MIN_US * (CLK_HZ / `RSC_HZ_PER_MHZ),
	parameter int unsigned FRS_CYC = `RSC_FRS_MIN_US * (CLK_HZ / `RSC_HZ_PER_MHZ),
	parameter int unsigned SMPS_CYC = `RSC_SMPS_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire rsc_pkg::rsc_axi_req_type axi_req,
	output rsc_pkg::rsc_axi_rsp_type axi_rsp,
	// power-on release and strap
	input wire logic power_on_release_n,
	input wire logic ext_regulation,
	input wire logic destructive_cause,
	input wire logic external_cause,
	// reset pin, open drain
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// device status
	output logic normal_run_state,
	output logic self_test_controller_run,
	output logic smps_test_run,
	output logic low_voltage_detector_en,
	output logic high_voltage_detector_en
);
	import rsc_pkg::*;

	logic [1:0] por_sync_reg;
	logic [1:0] pin_sync_reg;
	logic por_ok, pin_low;
	rsc_state_type state_reg;
	rsc_seq_type seq_reg;
	logic [31:0] timer_reg;
	logic [31:0] target_reg;
	logic ctrl_bist_reg, ctrl_func_long_reg, ctrl_pin_en_reg, ctrl_lvd_reg, ctrl_hvd_reg;
	logic ext_reg_reg;
	logic func_req_reg;
	logic destr_reg, extc_reg;
	logic bist_phase_reg;
	logic drive_pin_reg;
	logic smps_reg;
	logic done_flag_reg;
	logic [31:0] main_cyc, final_cyc;
	logic [2:0] strap_meta_reg;
	logic [2:0] strap_sync_reg;
	logic strap_ext_mode, strap_destr, strap_extc;

	// pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_sync_reg <= 2'h0;
			pin_sync_reg <= 2'h0;
			strap_meta_reg <= 3'h0;
			strap_sync_reg <= 3'h0;
		end else begin
			por_sync_reg <= {por_sync_reg[0], power_on_release_n};
			pin_sync_reg <= {pin_sync_reg[0], reset_pin_in};
			strap_meta_reg <= {ext_regulation, destructive_cause, external_cause};
			strap_sync_reg <= strap_meta_reg;
		end
	end
	assign {strap_ext_mode, strap_destr, strap_extc} = strap_sync_reg;
	assign por_ok = por_sync_reg[1];
	assign pin_low = !pin_sync_reg[1];

	// strap capture of mode and cause while held in power-on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_reg_reg <= 1'b0;
			destr_reg <= 1'b1;
			extc_reg <= 1'b0;
		end else if (state_reg == st_por_hold) begin
			ext_reg_reg <= strap_ext_mode;
			destr_reg <= strap_destr;
			extc_reg <= strap_extc;
		end
	end

	// phase lengths: main part, then final phase
	always_comb begin
		main_cyc = DR_CYC;
		final_cyc = 32'h0000_0001;
		case (seq_reg)
			seq_destr_bist: begin
				main_cyc = DRB_CYC - DR_CYC;
				final_cyc = DR_CYC;
			end
			seq_destr_plain: begin
				main_cyc = DR_CYC - SMPS_CYC;
				final_cyc = SMPS_CYC;
			end
			seq_ext_long_bist: begin
				main_cyc = ERLB_CYC - DR_CYC;
				final_cyc = DR_CYC;
			end
			seq_func_long: begin
				main_cyc = FRL_CYC - 32'h0000_0001;
				final_cyc = 32'h0000_0001;
			end
			seq_func_short: begin
				main_cyc = FRS_CYC;
				final_cyc = 32'h0000_0001;
			end
			default: begin
				main_cyc = DR_CYC;
				final_cyc = 32'h0000_0001;
			end
		endcase
	end

	// sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= st_por_hold;
			seq_reg <= seq_destr_plain;
			timer_reg <= 32'h0;
			target_reg <= 32'h0;
			bist_phase_reg <= 1'b0;
			smps_reg <= 1'b0;
			drive_pin_reg <= 1'b1;
			done_flag_reg <= 1'b0;
		end else begin
			timer_reg <= timer_reg + 32'h0000_0001;
			case (state_reg)
				st_por_hold: begin
					drive_pin_reg <= 1'b1;
					timer_reg <= 32'h0;
					if (por_ok) begin
						state_reg <= st_reset_run;
						if (destr_reg) begin
							seq_reg <= ctrl_bist_reg ? seq_destr_bist : seq_destr_plain;
							bist_phase_reg <= ctrl_bist_reg;
						end else begin
							seq_reg <= extc_reg ? seq_ext_long_bist : seq_destr_plain;
							bist_phase_reg <= extc_reg;
						end
					end
				end
				st_reset_run: begin
					target_reg <= main_cyc;
					if (timer_reg >= main_cyc) begin
						bist_phase_reg <= 1'b0;
						smps_reg <= (seq_reg == seq_destr_bist) || (seq_reg == seq_destr_plain);
						timer_reg <= 32'h0;
						state_reg <= st_final_phase;
					end
				end
				st_final_phase: begin
					target_reg <= final_cyc;
					if (timer_reg >= final_cyc) begin
						smps_reg <= 1'b0;
						drive_pin_reg <= 1'b0;
						state_reg <= st_pin_wait;
					end
				end
				st_pin_wait: begin
					if (!pin_low) begin
						state_reg <= st_normal_run;
						done_flag_reg <= 1'b1;
					end
				end
				st_normal_run: begin
					if (!por_ok) begin
						state_reg <= st_por_hold;
					end else if (func_req_reg) begin
						seq_reg <= ctrl_func_long_reg ? seq_func_long : seq_func_short;
						bist_phase_reg <= 1'b0;
						drive_pin_reg <= ctrl_pin_en_reg;
						timer_reg <= 32'h0;
						done_flag_reg <= 1'b0;
						state_reg <= st_reset_run;
					end
				end
				default: state_reg <= st_por_hold;
			endcase
			if (!por_ok && state_reg != st_por_hold) begin
				state_reg <= st_por_hold;
				drive_pin_reg <= 1'b1;
				bist_phase_reg <= 1'b0;
				smps_reg <= 1'b0;
				done_flag_reg <= 1'b0;
			end
		end
	end

	// registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_pin_out <= 1'b0;
			reset_pin_oe <= 1'b1;
			normal_run_state <= 1'b0;
			self_test_controller_run <= 1'b0;
			smps_test_run <= 1'b0;
			low_voltage_detector_en <= 1'b0;
			high_voltage_detector_en <= 1'b0;
		end else begin
			reset_pin_out <= 1'b0;
			reset_pin_oe <= drive_pin_reg;
			normal_run_state <= (state_reg == st_normal_run);
			self_test_controller_run <= bist_phase_reg && (state_reg == st_reset_run);
			smps_test_run <= smps_reg;
			low_voltage_detector_en <= ctrl_lvd_reg;
			high_voltage_detector_en <= ctrl_hvd_reg;
		end
	end

	// axi4-lite write path
	logic aw_held, w_held, bvalid_reg, awready_reg, wready_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg;
	logic wr_fire;
	assign wr_fire = aw_held && w_held && !bvalid_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			awaddr_reg <= 8'h0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			bresp_reg <= `RSC_RESP_OKAY;
		end else begin
			if (axi_req.awvalid && !aw_held) begin
				aw_held <= 1'b1;
				awready_reg <= 1'b0;
				awaddr_reg <= axi_req.awaddr;
			end
			if (axi_req.wvalid && !w_held) begin
				w_held <= 1'b1;
				wready_reg <= 1'b0;
				wdata_reg <= axi_req.wdata;
				wstrb_reg <= axi_req.wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
				bvalid_reg <= 1'b1;
				case (awaddr_reg)
					`RSC_OFS_CTRL, `RSC_OFS_CAUSE: bresp_reg <= `RSC_RESP_OKAY;
					default: bresp_reg <= `RSC_RESP_SLVERR;
				endcase
			end else if (bvalid_reg && axi_req.bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// control register; detectors default off when externally regulated
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{ctrl_hvd_reg, ctrl_lvd_reg, ctrl_pin_en_reg, ctrl_func_long_reg, ctrl_bist_reg} <= 5'(`RSC_CTRL_RESET);
		end else if (state_reg == st_por_hold) begin
			ctrl_lvd_reg <= !strap_ext_mode;
			ctrl_hvd_reg <= !strap_ext_mode;
		end else if (wr_fire && awaddr_reg == `RSC_OFS_CTRL && wstrb_reg[0]) begin
			ctrl_bist_reg <= wdata_reg[`RSC_CTRL_BIST];
			ctrl_func_long_reg <= wdata_reg[`RSC_CTRL_FUNC_LONG];
			ctrl_pin_en_reg <= wdata_reg[`RSC_CTRL_PIN_EN];
			ctrl_lvd_reg <= wdata_reg[`RSC_CTRL_LVD];
			ctrl_hvd_reg <= wdata_reg[`RSC_CTRL_HVD];
		end
	end

	// functional reset request, accepted only in normal run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			func_req_reg <= 1'b0;
		end else if (wr_fire && awaddr_reg == `RSC_OFS_CAUSE && wstrb_reg[0]
			&& wdata_reg[`RSC_CAUSE_FUNC] && state_reg == st_normal_run) begin
			func_req_reg <= 1'b1;
		end else if (state_reg != st_normal_run || func_req_reg) begin
			func_req_reg <= 1'b0;
		end
	end

	// axi4-lite read path
	logic rvalid_reg, arready_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
			rdata_reg <= 32'h0;
			rresp_reg <= `RSC_RESP_OKAY;
		end else if (axi_req.arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			arready_reg <= 1'b0;
			rresp_reg <= `RSC_RESP_OKAY;
			case (axi_req.araddr)
				`RSC_OFS_CTRL: rdata_reg <= {26'h0, ext_reg_reg, ctrl_hvd_reg, ctrl_lvd_reg,
					ctrl_pin_en_reg, ctrl_func_long_reg, ctrl_bist_reg};
				`RSC_OFS_CAUSE: rdata_reg <= {29'h0, extc_reg, destr_reg, func_req_reg};
				`RSC_OFS_STATUS: rdata_reg <= {22'h0, seq_reg, state_reg, done_flag_reg,
					pin_low, drive_pin_reg, bist_phase_reg};
				`RSC_OFS_PHASE: rdata_reg <= target_reg - timer_reg;
				default: begin
					rdata_reg <= 32'h0;
					rresp_reg <= `RSC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && axi_req.rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// bus outputs straight from flip-flops
	always_comb begin
		axi_rsp.awready = awready_reg;
		axi_rsp.wready = wready_reg;
		axi_rsp.bvalid = bvalid_reg;
		axi_rsp.bresp = bresp_reg;
		axi_rsp.arready = arready_reg;
		axi_rsp.rvalid = rvalid_reg;
		axi_rsp.rdata = rdata_reg;
		axi_rsp.rresp = rresp_reg;
	end
endmodule
